// [common/fsr_pkg.sv]
// Purpose: shared constants and types for the flash suspend/resume and
//          read-mode-exit command gate
// Assumes: ref_clk at 50 MHz, serial clock supplied by the host
// Notes:   opcodes are the serial flash command bytes, MSB first

package fsr_pkg;

	// ************************************************************
	// command codes
	// ************************************************************
	localparam logic [7:0] CMD_RD_EXIT = 8'hFF;
	localparam logic [7:0] CMD_PAUSE = 8'h75;
	localparam logic [7:0] CMD_CONT = 8'h7A;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_PROG = 8'h02;
	localparam logic [7:0] CMD_SE = 8'h20;
	localparam logic [7:0] CMD_BE32 = 8'h52;
	localparam logic [7:0] CMD_BE64 = 8'hD8;
	localparam logic [7:0] CMD_CE_A = 8'hC7;
	localparam logic [7:0] CMD_CE_B = 8'h60;
	localparam logic [7:0] CMD_WREN = 8'h06;

	// ************************************************************
	// field layout and values after reset
	// ************************************************************
	localparam logic [3:0] MODE_CONT_NIB = 4'hA;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ARRAY_ERASED = 8'hFF;
	localparam int STAT_BUSY_BIT = 0;
	localparam logic [3:0] CMD_LAST_BIT = 4'h7;
	localparam logic [3:0] CMD_OVER_BIT = 4'h8;
	localparam logic [3:0] BIT_CNT_MAX = 4'hF;
	localparam logic [2:0] SYNC_INIT = 3'h4;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int REF_MHZ = 50;
	localparam int SUS_MAX_US = 20;
	localparam int SUS_CYC = SUS_MAX_US * REF_MHZ;
	// chip select crossing before the pause starts, upper bound
	localparam int SUS_LAT_CYC = 8;
	localparam int PUW_MIN_MS = 1;
	localparam int PUW_CYC = PUW_MIN_MS * 1000 * REF_MHZ;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0]
	{
		FSR_RUN = 2'b00,
		FSR_PAUSING = 2'b01,
		FSR_PAUSED = 2'b11
	} fsr_state_t;

	typedef struct packed
	{
		logic vld;
		logic cont;
		logic [7:0] code;
	} fsr_disp_t;

	typedef struct packed
	{
		logic load;
		logic [7:0] bits;
	} fsr_mode_t;

endpackage : fsr_pkg

// [hdl/fsr_sync.sv]
// Purpose: two-flop level synchroniser, one lane per bit
// Assumes: each lane is a level or a toggle
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module fsr_sync
#(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)
(
	input wire logic clk, // destination clock
	input wire logic rst, // synchronous reset
	input wire logic [W-1:0] d, // foreign levels
	output logic [W-1:0] q // synchronised levels
);

	logic [W-1:0] meta;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= INIT;
			q <= INIT;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : fsr_sync

// [hdl/fsr_ctrl.sv]
// Purpose: command gate of a serial flash: continuous read mode exit,
//          erase/program pause and continue, power-up write gating
// Assumes: serial clock stops outside frames; engines run on ref_clk
// Notes:   the array and the command engines live outside this block
`timescale 1ns/1ps

module fsr_ctrl
	import fsr_pkg::*;
#(
	parameter int PUW_CYCLES = PUW_CYC
)
(
	input wire logic ref_clk, // system clock
	input wire logic rst, // reset, power loss; synchronous on ref_clk, asynchronous on the sclk side
	input wire logic sclk, // serial clock from host
	input wire logic cs_n, // chip select, active low
	input wire logic spi_io0, // first data line
	input wire logic op_wip, // erase/program running
	input wire fsr_mode_t mode_in, // continuous_read_bits from read engine
	output fsr_disp_t disp, // command handed to engines
	output logic refused, // command refused pulse
	output logic op_hold, // engines must stay paused
	output logic busy, // busy status bit
	output logic [7:0] status_byte, // status register image
	output logic cont_mode, // continuous read mode active
	output logic write_ok // powerup_write_delay elapsed
);

	localparam int SW = $clog2(SUS_CYC + 1);
	localparam int PW = $clog2(PUW_CYCLES + 1);
	localparam logic [SW-1:0] SUS_LAST = SW'(SUS_CYC - SUS_LAT_CYC - 1);
	localparam logic [PW-1:0] PUW_LAST = PW'(PUW_CYCLES - 1);

	// ************************************************************
	// link side, serial clock domain
	// ************************************************************
	logic [3:0] bit_cnt;
	logic [6:0] shreg;
	logic [7:0] cmd_byte;
	logic cmd_tgl;
	logic long_tgl;

	// bit counter restarts with every frame
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			bit_cnt <= 4'h0;
		else if (bit_cnt != BIT_CNT_MAX)
			bit_cnt <= bit_cnt + 4'h1;
	end

	always_ff @(posedge sclk)
	begin
		shreg <= {shreg[5:0], spi_io0};
	end

	// byte held until next frame's eighth clock
	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
		begin
			cmd_byte <= 8'h00;
			cmd_tgl <= 1'b0;
			long_tgl <= 1'b0;
		end
		else
		begin
			if (bit_cnt == CMD_LAST_BIT)
			begin
				cmd_byte <= {shreg, spi_io0};
				cmd_tgl <= ~cmd_tgl;
			end
			if (bit_cnt == CMD_OVER_BIT)
				long_tgl <= ~long_tgl;
		end
	end

	// ************************************************************
	// crossing into ref_clk
	// ************************************************************
	logic [2:0] sync_q;
	logic cmd_seen;
	logic long_seen;
	logic cs_d1;
	logic cs_d2;

	fsr_sync #(.W(3), .INIT(SYNC_INIT)) u_sync
	(
		.clk(ref_clk),
		.rst(rst),
		.d({cs_n, cmd_tgl, long_tgl}),
		.q(sync_q)
	);

	wire cmd_edge = sync_q[1] ^ cmd_seen;
	wire long_edge = sync_q[0] ^ long_seen;
	// extra stage lets toggles land before frame end
	wire frame_end = cs_d1 & ~cs_d2;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cmd_seen <= 1'b0;
			long_seen <= 1'b0;
			cs_d1 <= 1'b1;
			cs_d2 <= 1'b1;
		end
		else
		begin
			cmd_seen <= sync_q[1];
			long_seen <= sync_q[0];
			cs_d1 <= sync_q[2];
			cs_d2 <= cs_d1;
		end
	end

	// ************************************************************
	// pending command byte
	// ************************************************************
	logic pend_vld;
	logic pend_long;
	logic [7:0] pend_code;
	logic byte_evt;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pend_vld <= 1'b0;
			pend_long <= 1'b0;
			pend_code <= 8'h00;
			byte_evt <= 1'b0;
		end
		else
		begin
			byte_evt <= cmd_edge;
			if (frame_end)
				pend_vld <= 1'b0;
			if (cmd_edge)
			begin
				pend_vld <= 1'b1;
				pend_long <= 1'b0;
				pend_code <= cmd_byte;
			end
			if (long_edge)
				pend_long <= 1'b1;
		end
	end

	// ************************************************************
	// decode
	// ************************************************************
	fsr_state_t st;
	fsr_state_t next_st;

	wire code_exit = pend_code == CMD_RD_EXIT;
	wire code_pause = pend_code == CMD_PAUSE;
	wire code_cont = pend_code == CMD_CONT;
	wire code_local = code_exit | code_pause | code_cont;
	wire code_susp_blk = (pend_code == CMD_WRSR) | (pend_code == CMD_PROG)
		| (pend_code == CMD_SE) | (pend_code == CMD_BE32)
		| (pend_code == CMD_BE64) | (pend_code == CMD_CE_A)
		| (pend_code == CMD_CE_B);
	wire code_write = code_susp_blk | (pend_code == CMD_WREN);

	// byte-time decisions
	// commandless read
	wire cont_read = byte_evt & cont_mode & ~code_exit;
	wire spi_byte = byte_evt & ~cont_mode;
	wire blk_susp = spi_byte & code_susp_blk & (st != FSR_RUN);
	wire blk_pwr = spi_byte & code_write & ~write_ok;
	wire do_refuse = blk_susp | blk_pwr;
	wire do_disp = cont_read | (spi_byte & ~code_local & ~do_refuse);

	// frame-end decisions, exactly eight clocks
	wire fexec = frame_end & pend_vld & ~pend_long;
	wire do_exit = fexec & cont_mode & code_exit;
	wire do_pause = fexec & ~cont_mode & code_pause & op_wip
		& (st == FSR_RUN);
	wire do_resume = fexec & ~cont_mode & code_cont & (st == FSR_PAUSED);

	// ************************************************************
	// pause state machine
	// ************************************************************
	logic [SW-1:0] sus_cnt;

	wire sus_done = sus_cnt == SUS_LAST;

	always_comb
	begin
		case (st)
			FSR_RUN:
				next_st = do_pause ? FSR_PAUSING : FSR_RUN;
			FSR_PAUSING:
				next_st = sus_done ? FSR_PAUSED : FSR_PAUSING;
			FSR_PAUSED:
				next_st = do_resume ? FSR_RUN : FSR_PAUSED;
			default:
				next_st = FSR_RUN;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			st <= FSR_RUN;
		else
			st <= next_st;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || st != FSR_PAUSING)
			sus_cnt <= '0;
		else
			sus_cnt <= sus_cnt + SW'(1);
	end

	// ************************************************************
	// status and outputs
	// ************************************************************
	// busy while pausing
	wire next_busy = (next_st == FSR_PAUSING)
		| (op_wip & (next_st == FSR_RUN));
	wire [7:0] next_status = STATUS_RESET
		| (8'(next_busy) << STAT_BUSY_BIT);
	// mode load wins over exit
	wire next_cont = mode_in.load
		? (mode_in.bits[7:4] == MODE_CONT_NIB)
		: (cont_mode & ~do_exit);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			busy <= 1'b0;
			status_byte <= STATUS_RESET;
			op_hold <= 1'b0;
			cont_mode <= 1'b0;
		end
		else
		begin
			busy <= next_busy;
			status_byte <= next_status;
			op_hold <= next_st != FSR_RUN;
			cont_mode <= next_cont;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			disp <= '0;
			refused <= 1'b0;
		end
		else
		begin
			disp.vld <= do_disp;
			disp.cont <= cont_read;
			disp.code <= pend_code;
			refused <= do_refuse;
		end
	end

	// ************************************************************
	// power-up write delay
	// ************************************************************
	logic [PW-1:0] pwr_cnt;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pwr_cnt <= '0;
			write_ok <= 1'b0;
		end
		else if (!write_ok)
		begin
			pwr_cnt <= pwr_cnt + PW'(1);
			if (pwr_cnt == PUW_LAST)
				write_ok <= 1'b1;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_pause_go;
		do_pause;
	endsequence

	sequence s_settle;
		(st == FSR_PAUSING)[*8] ##[1:985] (st == FSR_PAUSED);
	endsequence

	property p_pause_bound;
		s_pause_go |=> s_settle;
	endproperty
	a_pause_bound: assert property (p_pause_bound)
		else $error("pause did not settle in time");

	property p_busy_pausing;
		(st == FSR_PAUSING) |-> busy && status_byte[STAT_BUSY_BIT];
	endproperty
	a_busy_pausing: assert property (p_busy_pausing)
		else $error("busy low while pausing");

	property p_idle_paused;
		(st == FSR_PAUSED) && $past(st == FSR_PAUSED) |-> !busy;
	endproperty
	a_idle_paused: assert property (p_idle_paused)
		else $error("busy high after pause settled");

	property p_pause_idle;
		fexec && code_pause && !cont_mode && !op_wip && st == FSR_RUN
			|=> st == FSR_RUN && !op_hold;
	endproperty
	a_pause_idle: assert property (p_pause_idle)
		else $error("pause taken with nothing running");

	property p_pause_hold;
		s_pause_go |=> op_hold;
	endproperty
	a_pause_hold: assert property (p_pause_hold)
		else $error("pause did not hold the operation");

	property p_resume_busy;
		do_resume && op_wip |=> busy && !op_hold && st == FSR_RUN;
	endproperty
	a_resume_busy: assert property (p_resume_busy)
		else $error("continue did not restart operation");

	property p_resume_ign;
		fexec && code_cont && st == FSR_RUN |=> st == FSR_RUN;
	endproperty
	a_resume_ign: assert property (p_resume_ign)
		else $error("continue acted with nothing paused");

	property p_refuse_susp;
		spi_byte && code_susp_blk && st != FSR_RUN
			|=> refused && !disp.vld;
	endproperty
	a_refuse_susp: assert property (p_refuse_susp)
		else $error("blocked command passed while paused");

	property p_refuse_pwr;
		!write_ok && spi_byte && code_write |=> refused && !disp.vld;
	endproperty
	a_refuse_pwr: assert property (p_refuse_pwr)
		else $error("write accepted before power-up delay");

	property p_no_decode;
		byte_evt && cont_mode |=> !(disp.vld && !disp.cont);
	endproperty
	a_no_decode: assert property (p_no_decode)
		else $error("ordinary command decoded in continuous mode");

	property p_cont_read;
		cont_read |=> disp.vld && disp.cont;
	endproperty
	a_cont_read: assert property (p_cont_read)
		else $error("commandless read not handed on");

	property p_exit;
		do_exit && !mode_in.load |=> !cont_mode;
	endproperty
	a_exit: assert property (p_exit)
		else $error("exit code left continuous mode set");

endmodule : fsr_ctrl

// [sim/fsr_host.sv]
// Purpose: host controller model driving the serial link
// Assumes: serial clock of 30 ns, only inside frames
// Notes:   data line shows inverted last bit when not driven
`timescale 1ns/1ps

module fsr_host
(
	input wire logic go, // start one frame
	input wire logic [7:0] code, // first byte, msb first
	input wire logic [4:0] edges, // rising edges in frame
	output logic sclk, // serial clock
	output logic cs_n, // chip select, active low
	output logic spi_io0, // first data line
	output logic done // frame finished
);
	// ************************************************************
	// frame generator
	// ************************************************************
	int i;

	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		spi_io0 = 1'b0;
		done = 1'b0;
	end

	always @(posedge go)
	begin
		done = 1'b0;
		#7 cs_n = 1'b0;
		for (i = 0; i < edges; i++)
		begin
			spi_io0 = (i < 8) ? code[7 - i] : ~spi_io0;
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
		#5 cs_n = 1'b1;
		spi_io0 = ~spi_io0;
		#30 done = 1'b1;
	end
endmodule : fsr_host

// [sim/tb_top.sv]
// Purpose: self-checking bench for the flash command gate
// Assumes: host model drives the link, ref_clk 50 MHz
// Notes:   power-up write delay shortened to PUW cycles
`timescale 1ns/1ps

module tb_top
	import fsr_pkg::*;
;
	// ************************************************************
	// signals and instances
	// ************************************************************
	localparam int PUW = 40;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic op_wip = 1'b0;
	logic go = 1'b0;
	logic [7:0] code = 8'h00;
	logic [4:0] edges = 5'h08;
	fsr_mode_t mode_in = '0;
	logic sclk, cs_n, spi_io0, done;
	fsr_disp_t disp, last;
	logic refused, op_hold, busy, cont_mode, write_ok;
	logic [7:0] status_byte;
	int n_errors = 0;
	int checked = 0;
	int n_disp = 0;
	int n_ref = 0;
	int cyc = 0;

	always #10 ref_clk = ~ref_clk;

	fsr_host fsr_host_inst (.go(go), .code(code), .edges(edges),
		.sclk(sclk), .cs_n(cs_n), .spi_io0(spi_io0), .done(done));

	fsr_ctrl #(.PUW_CYCLES(PUW)) fsr_ctrl_inst (.ref_clk(ref_clk),
		.rst(rst), .sclk(sclk), .cs_n(cs_n), .spi_io0(spi_io0),
		.op_wip(op_wip), .mode_in(mode_in), .disp(disp),
		.refused(refused), .op_hold(op_hold), .busy(busy),
		.status_byte(status_byte), .cont_mode(cont_mode),
		.write_ok(write_ok));

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (disp.vld === 1'b1)
		begin
			last <= disp;
			n_disp <= n_disp + 1;
		end
		if (refused === 1'b1)
			n_ref <= n_ref + 1;
		if (cyc == 8000)
		begin
			n_errors = n_errors + 1;
			close_out();
		end
	end

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic close_out();
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic frame(input logic [7:0] c, input logic [4:0] e);
		@(posedge ref_clk);
		code <= c;
		edges <= e;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		while (done !== 1'b1)
			@(posedge ref_clk);
		tick(6);
	endtask : frame

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_powerup();
		int r0;
		r0 = n_ref;
		chk(status_byte, 8'h00);
		chk({7'h0, write_ok}, 8'h00);
		frame(8'h06, 5'h08);
		chk(8'(n_ref - r0), 8'h01);
		tick(PUW);
		chk({7'h0, write_ok}, 8'h01);
		frame(8'h06, 5'h08);
		chk(last.code, 8'h06);
		chk(8'(n_ref - r0), 8'h01);
	endtask : t_powerup

	task automatic t_idle();
		int d0;
		d0 = n_disp;
		frame(8'h75, 5'h08);
		chk({7'h0, op_hold}, 8'h00);
		frame(8'h7A, 5'h08);
		chk({6'h0, op_hold, busy}, 8'h00);
		chk(8'(n_disp - d0), 8'h00);
		frame(8'h03, 5'h10);
		chk({7'h0, last.cont}, 8'h00);
		chk(last.code, 8'h03);
	endtask : t_idle

	task automatic t_pause();
		logic [7:0] bad [7] = '{8'h01, 8'h02, 8'h20, 8'h52, 8'hD8,
			8'hC7, 8'h60};
		int r0;
		int d0;
		op_wip <= 1'b1;
		tick(2);
		chk(status_byte, 8'h01);
		frame(8'h75, 5'h08);
		chk({6'h0, op_hold, busy}, 8'h03);
		tick(880);
		chk(status_byte, 8'h01);
		tick(110);
		chk({6'h0, op_hold, busy}, 8'h02);
		d0 = n_disp;
		for (int j = 0; j < 7; j++)
		begin
			r0 = n_ref;
			frame(bad[j], 5'h08);
			chk(8'(n_ref - r0), 8'h01);
		end
		chk(8'(n_disp - d0), 8'h00);
		frame(8'h0B, 5'h10);
		chk(last.code, 8'h0B);
		frame(8'h7A, 5'h08);
		chk({6'h0, op_hold, busy}, 8'h01);
		op_wip <= 1'b0;
		tick(2);
		chk(status_byte, 8'h00);
	endtask : t_pause

	task automatic t_cont();
		int d0;
		@(posedge ref_clk);
		mode_in <= '{1'b1, 8'hA5};
		@(posedge ref_clk);
		mode_in.load <= 1'b0;
		tick(2);
		chk({7'h0, cont_mode}, 8'h01);
		frame(8'h9F, 5'h10);
		chk({7'h0, last.cont}, 8'h01);
		chk(last.code, 8'h9F);
		d0 = n_disp;
		frame(8'hFF, 5'h08);
		chk({7'h0, cont_mode}, 8'h00);
		chk(8'(n_disp - d0), 8'h00);
		frame(8'h0B, 5'h10);
		chk({7'h0, last.cont}, 8'h00);
		chk(last.code, 8'h0B);
		@(posedge ref_clk);
		mode_in <= '{1'b1, 8'h5A};
		@(posedge ref_clk);
		mode_in.load <= 1'b0;
		tick(2);
		chk({7'h0, cont_mode}, 8'h00);
	endtask : t_cont

	task automatic t_lost();
		op_wip <= 1'b1;
		frame(8'h75, 5'h08);
		chk({7'h0, op_hold}, 8'h01);
		op_wip <= 1'b0;
		rst <= 1'b1;
		tick(6);
		rst <= 1'b0;
		tick(3);
		chk({6'h0, op_hold, write_ok}, 8'h00);
		chk(status_byte, 8'h00);
	endtask : t_lost

	initial
	begin
		tick(6);
		rst <= 1'b0;
		tick(3);
		t_powerup();
		t_idle();
		t_pause();
		t_cont();
		t_lost();
		close_out();
	end
endmodule : tb_top
